/* design/hpsp_pkg.sv */
// Shared constants for the hub port strap and power control block.
package hpsp_pkg;
  localparam int          HPSP_PORTS       = 4;
  localparam int          HPSP_SYNC_STAGES = 2;
  // Reset value of the per-port power enables: all ports unpowered.
  localparam logic [3:0]  HPSP_PWR_RESET   = 4'h0;
  // Reset value of captured strap bits.
  localparam logic [3:0]  HPSP_STRAP_RESET = 4'h0;
  // Output enables of the shared supply pins while released: all high.
  localparam logic [3:0]  HPSP_OE_RELEASED = 4'hF;
  // Time in ns that upstream power sense must hold before the connect state changes.
  localparam int          HPSP_SENSE_DEB_NS = 1000;
  localparam int          HPSP_CLK_NS       = 25;
  localparam int          HPSP_SENSE_DEB_CYC =
    (HPSP_SENSE_DEB_NS + HPSP_CLK_NS - 1) / HPSP_CLK_NS;
  localparam int          HPSP_DEB_W        = 6;

  typedef enum logic [1:0] {
    HPSP_ST_RESET   = 2'b00,
    HPSP_ST_CAPTURE = 2'b01,
    HPSP_ST_RUN     = 2'b10
  } hpsp_state_t;
endpackage : hpsp_pkg

/* design/hpsp_sync.sv */
// Two-flop synchroniser for a vector of asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none
module hpsp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule : hpsp_sync
`default_nettype wire

/* design/hpsp_top.sv */
// Upstream connect control, reset strap capture and port power enables.
`timescale 1ns/1ps
`default_nettype none
module hpsp_top
  import hpsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Asynchronous pin levels; each passes two flops before use.
  input  wire logic       upstream_power_sense,
  input  wire logic       port_off_strap_en,
  input  wire logic       charge_strap_en,
  input  wire logic [3:0] port_off_strap_minus,
  input  wire logic [3:0] port_off_strap_plus,
  input  wire logic [3:0] charge_support_strap,
  // Request from hub logic on this clock, used directly.
  input  wire logic [3:0] port_power_req,
  // All outputs below are register outputs.
  output var  logic       upstream_dplus_pullup,
  output var  logic [3:0] port_supply_on,
  output var  logic [3:0] port_supply_oe_n,
  output var  logic [3:0] port_disabled,
  output var  logic [3:0] port_charge_support,
  output var  logic       straps_valid
);
  // The enable pins double as charge straps, so they are released (input)
  // until straps are captured; output enable is low while driving.
  logic [13:0] pins_async;
  logic [13:0] pins_sync;
  logic        sense_sync;
  logic [3:0]  dm_sync;
  logic [3:0]  dp_sync;
  logic [3:0]  chg_sync;
  logic        pen_sync;
  logic        cen_sync;

  // Every pin level crosses into the clock domain through two flops.
  assign pins_async = {upstream_power_sense, port_off_strap_en,
                       charge_strap_en, port_off_strap_minus,
                       port_off_strap_plus, charge_support_strap[2:0]};

  hpsp_sync #(.WIDTH(14)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  // The fourth enable pin passes through a one-bit synchroniser of its own.
  logic chg3_sync;

  hpsp_sync #(.WIDTH(1)) u_sync_chg3 (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (charge_support_strap[3]),
    .sync_out (chg3_sync)
  );

  always_comb begin
    sense_sync = pins_sync[13];
    pen_sync   = pins_sync[12];
    cen_sync   = pins_sync[11];
    dm_sync    = pins_sync[10:7];
    dp_sync    = pins_sync[6:3];
    chg_sync   = {chg3_sync, pins_sync[2:0]};
  end

  // Strap capture sequence. The synchronisers are held in reset with the
  // rest of the block, so a level present at release reaches them two
  // edges later; the wait count covers that before the one capture.
  // The straps must therefore stand for a few cycles after release, and
  // the captured values then hold until reset_n is asserted again.
  hpsp_state_t state_q;
  hpsp_state_t state_d;
  logic [1:0]  wait_q;
  logic [1:0]  wait_d;
  logic [3:0]  dis_q;
  logic [3:0]  dis_d;
  logic [3:0]  chg_q;
  logic [3:0]  chg_d;
  logic        valid_q;
  logic        valid_d;

  always_comb begin
    state_d = state_q;
    wait_d  = wait_q;
    dis_d   = dis_q;
    chg_d   = chg_q;
    valid_d = valid_q;
    case (state_q)
      HPSP_ST_RESET: begin
        // Count edges until the synchronisers hold post-release levels.
        wait_d = wait_q + 2'd1;
        if (wait_q == 2'(HPSP_SYNC_STAGES)) begin
          state_d = HPSP_ST_CAPTURE;
        end
      end
      HPSP_ST_CAPTURE: begin
        // Levels now seen are those present at the second clock edge after reset_n rose.
        // A strap group whose option is off keeps its reset value of zero.
        if (pen_sync) begin
          dis_d = dm_sync & dp_sync;
        end
        if (cen_sync) begin
          chg_d = chg_sync;
        end
        valid_d = 1'b1;
        state_d = HPSP_ST_RUN;
      end
      HPSP_ST_RUN: begin
        // Straps stay frozen here whatever the shared pins do later.
        state_d = HPSP_ST_RUN;
      end
      default: begin
        wait_d  = '0;
        state_d = HPSP_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= HPSP_ST_RESET;
      wait_q  <= 2'd0;
      dis_q   <= HPSP_STRAP_RESET;
      chg_q   <= HPSP_STRAP_RESET;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
      dis_q   <= dis_d;
      chg_q   <= chg_d;
      valid_q <= valid_d;
    end
  end

  // Upstream power sense debounce and connect pull-up. A new sense level
  // must stand for the whole debounce span before the pull-up follows, so
  // a bouncing supply contact gives the host one clean connect. The
  // pull-up only rises once the straps are valid, so the host never sees
  // a connect before the port set-up is known.
  logic [HPSP_DEB_W-1:0] deb_q;
  logic [HPSP_DEB_W-1:0] deb_d;
  logic                  pull_q;
  logic                  pull_d;

  always_comb begin
    deb_d  = deb_q;
    pull_d = pull_q;
    if (sense_sync == pull_q) begin
      // Sense agrees with the pull-up: nothing pending, restart the count.
      deb_d = '0;
    end else if (deb_q == HPSP_DEB_W'(HPSP_SENSE_DEB_CYC - 1)) begin
      // Span complete: follow the sense, but never connect before valid.
      deb_d  = '0;
      pull_d = sense_sync & valid_q;
    end else begin
      deb_d = deb_q + HPSP_DEB_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      deb_q  <= '0;
      pull_q <= 1'b0;
    end else begin
      deb_q  <= deb_d;
      pull_q <= pull_d;
    end
  end

  // Port supply enables, active high, gated off for disabled ports. The
  // pins are also the charge straps, so until capture they stay released
  // and unpowered; only then is the output enable pulled low.
  logic [3:0] pwr_d;
  logic [3:0] pwr_q;
  logic [3:0] oe_n_d;
  logic [3:0] oe_n_q;

  always_comb begin
    pwr_d  = HPSP_PWR_RESET;
    oe_n_d = HPSP_OE_RELEASED;
    if (valid_q) begin
      // Straps known: drive every pin and pass requests of enabled ports.
      pwr_d  = port_power_req & ~dis_q;
      oe_n_d = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwr_q  <= HPSP_PWR_RESET;
      oe_n_q <= HPSP_OE_RELEASED;
    end else begin
      pwr_q  <= pwr_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Outputs come straight from the registers above.
  always_comb begin
    upstream_dplus_pullup = pull_q;
    port_supply_on        = pwr_q;
    port_supply_oe_n      = oe_n_q;
    port_disabled         = dis_q;
    port_charge_support   = chg_q;
    straps_valid          = valid_q;
  end
endmodule : hpsp_top
`default_nettype wire

/* test/hpsp_chk.sv */
// Checker for strap capture, power enables and the pull-up.
`timescale 1ns/1ps
`default_nettype none
module hpsp_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       upstream_power_sense,
  input wire logic       port_off_strap_en,
  input wire logic       charge_strap_en,
  input wire logic [3:0] port_off_strap_minus,
  input wire logic [3:0] port_off_strap_plus,
  input wire logic [3:0] charge_support_strap,
  input wire logic [3:0] port_power_req,
  input wire logic       upstream_dplus_pullup,
  input wire logic [3:0] port_supply_on,
  input wire logic [3:0] port_supply_oe_n,
  input wire logic [3:0] port_disabled,
  input wire logic [3:0] port_charge_support,
  input wire logic       straps_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  rst_quiet_a: assert property (disable iff (1'b0)
    !reset_n |=> !straps_valid && port_supply_oe_n == 4'hF)
    else $error("active in reset");
  valid_time_a: assert property (
    $rose(reset_n) |-> ##[3:6] straps_valid) else $error("late straps");
  strap_hold_a: assert property (
    straps_valid |=> straps_valid && $stable(port_disabled)
    && $stable(port_charge_support)) else $error("straps moved");
  supply_follow_a: assert property (
    straps_valid |=> port_supply_on ==
    ($past(port_power_req) & ~port_disabled)) else $error("bad supply");
  no_pwr_early_a: assert property (
    !straps_valid |-> port_supply_on == 4'h0) else $error("early supply");
  dis_cap_a: assert property (
    $rose(straps_valid) |-> port_disabled == ($past(port_off_strap_minus,3)
    & $past(port_off_strap_plus,3) & {4{$past(port_off_strap_en,3)}}))
    else $error("bad disable");
  chg_cap_a: assert property (
    $rose(straps_valid) |-> port_charge_support == ({4{$past(
    charge_strap_en,3)}} & $past(charge_support_strap,3)))
    else $error("bad charge");
  pullup_src_a: assert property (
    $changed(upstream_dplus_pullup) |-> upstream_dplus_pullup ==
    $past(upstream_power_sense,8)) else $error("bad pull-up");
  oe_drive_a: assert property (
    straps_valid |=> port_supply_oe_n == 4'h0) else $error("pins undriven");
  pull_gate_a: assert property (
    !straps_valid |-> !upstream_dplus_pullup) else $error("early pull-up");
endmodule : hpsp_chk
bind hpsp_top hpsp_chk i_hpsp_chk (.*);
`default_nettype wire

/* test/hpsp_partner.sv */
// Port power switches and charge strap resistors beside the hub.
`timescale 1ns/1ps
`default_nettype none
module hpsp_partner (
  input  wire logic [3:0] port_supply_on,
  input  wire logic [3:0] port_supply_oe_n,
  input  wire logic [3:0] pull,
  output var  logic [3:0] charge_support_strap,
  output var  logic [3:0] powered
);
  // The pin shows the enable when driven, else the resistor level.
  always_comb charge_support_strap = (port_supply_on & ~port_supply_oe_n)
    | (pull & port_supply_oe_n);
  always_comb powered = port_supply_on;
endmodule : hpsp_partner
`default_nettype wire

/* test/hpsp_top_tb.sv */
// Self-checking bench for the hub strap and power block.
`timescale 1ns/1ps
`default_nettype none
module hpsp_top_tb;
  logic       clk, reset_n, upstream_power_sense, port_off_strap_en;
  logic       charge_strap_en, upstream_dplus_pullup, straps_valid;
  logic [3:0] port_off_strap_minus, port_off_strap_plus, pull, powered;
  logic [3:0] charge_support_strap, port_power_req, port_supply_on;
  logic [3:0] port_supply_oe_n, port_disabled, port_charge_support;
  int         errors, checks_done;
  logic [7:0] rows [4] = '{8'hFC, 8'h44, 8'h20, 8'h88};
  hpsp_top i_hpsp_top (.*);
  hpsp_partner i_hpsp_partner (.*);
  task automatic chk(input logic [3:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic rst(input logic p, c);
    reset_n = 0;
    port_off_strap_en = p;
    charge_strap_en = c;
    step(4);
    chk(port_supply_oe_n, 4'hF);
    reset_n = 1;
    step(8);
    chk({3'h0, straps_valid}, 4'h1);
    chk(port_supply_oe_n, 4'h0);
  endtask : rst
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #100000;
    errors++;
    close_out();
  end
  initial begin
    {reset_n, upstream_power_sense, port_power_req} = '0;
    port_off_strap_minus = 4'hB;
    port_off_strap_plus = 4'h3;
    pull = 4'h5;
    rst(1, 1);
    chk(port_disabled, 4'h3);
    chk(port_charge_support, 4'h5);
    {port_off_strap_minus, port_off_strap_plus, pull} = '1;
    foreach (rows[i]) begin
      port_power_req = rows[i][7:4];
      step(2);
      chk(powered, rows[i][3:0]);
    end
    chk(port_disabled, 4'h3);
    upstream_power_sense = 1;
    step(30);
    chk({3'h0, upstream_dplus_pullup}, 4'h0);
    step(20);
    chk({3'h0, upstream_dplus_pullup}, 4'h1);
    upstream_power_sense = 0;
    step(20);
    chk({3'h0, upstream_dplus_pullup}, 4'h1);
    step(30);
    chk({3'h0, upstream_dplus_pullup}, 4'h0);
    rst(0, 0);
    chk(port_disabled, 4'h0);
    chk(port_charge_support, 4'h0);
    step(2);
    chk(port_supply_on, 4'h8);
    close_out();
  end
endmodule : hpsp_top_tb
`default_nettype wire
